// ### hdl/lin_div_pkg.sv
// Constants, types and helpers shared by the divider update logic.
package lin_div_pkg;
   localparam int unsigned DIV_W      = 16;
   localparam int unsigned SYNC_CNT_W = 19;
   localparam int unsigned ADDR_W     = 5;
   localparam int unsigned ST_W       = 5;
   localparam logic [2:0]  LAST_EDGE_IDX = 3'h4;
   localparam logic [7:0]  SYNC_BYTE     = 8'h55;
   // Tolerances as ratios: 14 % is 14/100, 3.75 % is 15/400.
   localparam logic [31:0] HDR_DEV_NUM   = 32'h0000000E;
   localparam logic [31:0] HDR_DEV_DEN   = 32'h00000064;
   localparam logic [31:0] CHAR_DEV_NUM  = 32'h0000000F;
   localparam logic [31:0] CHAR_DEV_DEN  = 32'h00000190;
   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFS_DIV_A  = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_DIV_B  = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_MASK   = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_ACTIVE = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_RXDATA = 5'h18;
   // Field positions.
   localparam int unsigned CTRL_ASE_BIT = 0;
   localparam int unsigned CTRL_UPD_BIT = 1;
   localparam int unsigned ST_HDR_BIT   = 0;
   localparam int unsigned ST_HERR_BIT  = 1;
   localparam int unsigned ST_RECEIVE_NOT_EMPTY_FLAG_BIT  = 2;
   localparam int unsigned ST_MEAS_BIT  = 3;
   localparam int unsigned ST_DRIFT_BIT = 4;
   // Reset values.
   localparam logic [DIV_W-1:0] DIV_RST  = 16'h0000;
   localparam logic [1:0]       CTRL_RST = 2'h0;
   localparam logic [ST_W-1:0]  ST_RST   = 5'h00;
   localparam logic [7:0]       RXD_RST  = 8'h00;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {HDR_IDLE, HDR_MEASURE, HDR_WAIT_SYNC} hdr_state_t;

   // True when |meas - ref| exceeds num/den of ref.
   function automatic logic deviation_exceeds(input logic [DIV_W-1:0] meas,
                                              input logic [DIV_W-1:0] ref_div,
                                              input logic [31:0]      num,
                                              input logic [31:0]      den);
      logic [31:0] diff;
      diff = (meas > ref_div) ? {16'h0000, meas - ref_div} : {16'h0000, ref_div - meas};
      return (diff * den) > ({16'h0000, ref_div} * num);
   endfunction

   // Middle byte of a divider, as seen in register A.
   function automatic logic [7:0] div_word_a(input logic [DIV_W-1:0] d);
      return d[11:4];
   endfunction

   // Top nibble and low nibble of a divider, as seen in register B.
   function automatic logic [7:0] div_word_b(input logic [DIV_W-1:0] d);
      return {d[15:12], d[3:0]};
   endfunction
endpackage

// ### hdl/sync_period_meter.sv
// Measures the span of five falling receive edges after a break.
`timescale 1ns/100ps
`default_nettype none
module sync_period_meter
(
   // Clock and reset
   input  wire logic                                 aclk,
   input  wire logic                                 aresetn,
   // Control and line
   input  wire logic                                 start,
   input  wire logic                                 rx_in,
   // Result
   output logic                                      done,
   output logic [lin_div_pkg::SYNC_CNT_W-1:0]        period
);
   logic                                  rx_prev_reg;
   logic                                  busy_reg;
   logic [2:0]                            edge_cnt_reg;
   logic [lin_div_pkg::SYNC_CNT_W-1:0]    sync_period_counter_reg;
   logic                                  falling;

   assign falling = rx_prev_reg & ~rx_in;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rx_prev_reg <= 1'b1;
      else
         rx_prev_reg <= rx_in;
   end

   // Counts clocks from the first to the fifth falling edge.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         busy_reg                <= 1'b0;
         edge_cnt_reg            <= 3'h0;
         sync_period_counter_reg <= 19'h00000;
         done                    <= 1'b0;
         period                  <= 19'h00000;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            busy_reg                <= 1'b1;
            edge_cnt_reg            <= 3'h0;
            sync_period_counter_reg <= 19'h00000;
         end
         else if (busy_reg)
         begin
            if (edge_cnt_reg != 3'h0 && sync_period_counter_reg != 19'h7FFFF)
               sync_period_counter_reg <= sync_period_counter_reg + 19'h00001;
            if (falling)
            begin
               edge_cnt_reg <= edge_cnt_reg + 3'h1;
               if (edge_cnt_reg == lin_div_pkg::LAST_EDGE_IDX)
               begin
                  busy_reg <= 1'b0;
                  done     <= 1'b1;
                  period   <= sync_period_counter_reg;
               end
            end
         end
      end
   end

   a_fifth_edge_done : assert property (@(posedge aclk) disable iff (!aresetn)
      busy_reg && !start && falling && edge_cnt_reg == 3'h4 |=> done && !busy_reg)
      else $error("Fifth falling edge did not end the measurement.");
endmodule // sync_period_meter
`default_nettype wire

// ### hdl/baud_rate_gen.sv
// Produces one bit-time tick every active divider clocks.
`timescale 1ns/100ps
`default_nettype none
module baud_rate_gen
(
   // Clock and reset
   input  wire logic                            aclk,
   input  wire logic                            aresetn,
   // Divider and tick
   input  wire logic [lin_div_pkg::DIV_W-1:0]   divider,
   output logic                                 tick
);
   logic [lin_div_pkg::DIV_W-1:0] count_reg;

   // A zero divider holds the generator still.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_reg <= 16'h0000;
         tick      <= 1'b0;
      end
      else if (divider == 16'h0000)
      begin
         count_reg <= 16'h0000;
         tick      <= 1'b0;
      end
      else if (count_reg >= divider - 16'h0001)
      begin
         count_reg <= 16'h0000;
         tick      <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + 16'h0001;
         tick      <= 1'b0;
      end
   end
endmodule // baud_rate_gen
`default_nettype wire

// ### hdl/lin_baud_divider_update.sv
// Divider holding, update and header checking with an AXI4-Lite register slave.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Nominal divider captures software writes.
// - Measured divider holds each sync measurement.
// - Active divider drives generator, loaded nominal/measured.
// - Auto resync copies measured into active.
// - Update mode 1: nominal loads on receive.
// - Update mode 0: nominal loads on register A.
// - Simultaneous loads: nominal value wins.
// - Total character clock deviation below 3.75 percent; larger drift up to 14 percent only sets the drift status bit, above 14 percent it sets header error.
// - Count clocks over five falling edges.
// - Measured divider readable through divider registers.
// - Bad header: error flag, no detect flag.
// - Header error on bad sync or deviation.
module lin_baud_divider_update
(
   // Clock and reset
   input  wire logic                                 aclk,
   input  wire logic                                 aresetn,
   // AXI4-Lite write address and data
   input  wire logic [lin_div_pkg::ADDR_W-1:0]       awaddr,
   input  wire logic                                 awvalid,
   output logic                                      awready,
   input  wire logic [31:0]                          wdata,
   input  wire logic [3:0]                           wstrb,
   input  wire logic                                 wvalid,
   output logic                                      wready,
   // AXI4-Lite write response
   output logic [1:0]                                bresp,
   output logic                                      bvalid,
   input  wire logic                                 bready,
   // AXI4-Lite read
   input  wire logic [lin_div_pkg::ADDR_W-1:0]       araddr,
   input  wire logic                                 arvalid,
   output logic                                      arready,
   output logic [31:0]                               rdata,
   output logic [1:0]                                rresp,
   output logic                                      rvalid,
   input  wire logic                                 rready,
   // Receiver side
   input  wire logic                                 rx_in,
   input  wire logic                                 break_detected,
   input  wire logic                                 rx_char_valid,
   input  wire logic [7:0]                           rx_char,
   // Outputs
   output logic [lin_div_pkg::DIV_W-1:0]             active_rate_divider,
   output logic                                      baud_tick,
   output logic                                      irq
);
   logic [lin_div_pkg::DIV_W-1:0]        nominal_rate_divider_reg;
   logic [lin_div_pkg::DIV_W-1:0]        nominal_rate_divider_next;
   logic [lin_div_pkg::DIV_W-1:0]        measured_rate_divider_reg;
   logic [lin_div_pkg::DIV_W-1:0]        meas_value;
   logic [1:0]                           ctrl_reg;
   logic [lin_div_pkg::ST_W-1:0]         status_reg;
   logic [lin_div_pkg::ST_W-1:0]         status_set;
   logic [lin_div_pkg::ST_W-1:0]         status_clr;
   logic [lin_div_pkg::ST_W-1:0]         mask_reg;
   logic [7:0]                           rx_data_reg;
   logic                                 show_meas_reg;
   lin_div_pkg::hdr_state_t              hdr_state_reg;
   logic                                 wr_fire;
   logic                                 rd_fire;
   logic                                 wr_a;
   logic                                 wr_b;
   logic                                 wr_ok;
   logic                                 rd_ok;
   logic [31:0]                          rd_word;
   logic                                 auto_resync_enable;
   logic                                 divider_update_mode;
   logic                                 meas_done;
   logic [lin_div_pkg::SYNC_CNT_W-1:0]   meas_period;
   logic                                 dev_err;
   logic                                 meas_ok;
   logic                                 nom_load;
   logic                                 meas_load;

   assign auto_resync_enable  = ctrl_reg[lin_div_pkg::CTRL_ASE_BIT];
   assign divider_update_mode = ctrl_reg[lin_div_pkg::CTRL_UPD_BIT];

   // Write channel: address and data are taken together, one write at a time.
   assign wr_fire = awvalid & wvalid & ~bvalid;
   assign awready = wr_fire;
   assign wready  = wr_fire;
   assign wr_a    = wr_fire & wstrb[0] & (awaddr == lin_div_pkg::OFS_DIV_A);
   assign wr_b    = wr_fire & wstrb[0] & (awaddr == lin_div_pkg::OFS_DIV_B);

   always_comb
   begin
      unique case (awaddr)
         lin_div_pkg::OFS_DIV_A,
         lin_div_pkg::OFS_DIV_B,
         lin_div_pkg::OFS_CTRL,
         lin_div_pkg::OFS_STATUS,
         lin_div_pkg::OFS_MASK,
         lin_div_pkg::OFS_ACTIVE,
         lin_div_pkg::OFS_RXDATA: wr_ok = 1'b1;
         default:                 wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp  <= lin_div_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid <= 1'b1;
         bresp  <= wr_ok ? lin_div_pkg::RESP_OKAY : lin_div_pkg::RESP_DECERR;
      end
      else if (bready)
         bvalid <= 1'b0;
   end
   // Read channel: one read at a time, data registered.
   assign rd_fire = arvalid & ~rvalid;
   assign arready = rd_fire;

   always_comb
   begin
      rd_ok   = 1'b1;
      rd_word = 32'h00000000;
      unique case (araddr)
         lin_div_pkg::OFS_DIV_A:
            rd_word[7:0] = show_meas_reg ? lin_div_pkg::div_word_a(measured_rate_divider_reg)
                                         : lin_div_pkg::div_word_a(nominal_rate_divider_reg);
         lin_div_pkg::OFS_DIV_B:
            rd_word[7:0] = show_meas_reg ? lin_div_pkg::div_word_b(measured_rate_divider_reg)
                                         : lin_div_pkg::div_word_b(nominal_rate_divider_reg);
         lin_div_pkg::OFS_CTRL:   rd_word[1:0] = ctrl_reg;
         lin_div_pkg::OFS_STATUS: rd_word[lin_div_pkg::ST_W-1:0] = status_reg;
         lin_div_pkg::OFS_MASK:   rd_word[lin_div_pkg::ST_W-1:0] = mask_reg;
         lin_div_pkg::OFS_ACTIVE: rd_word[15:0] = active_rate_divider;
         lin_div_pkg::OFS_RXDATA: rd_word[7:0] = rx_data_reg;
         default:                 rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= lin_div_pkg::RESP_OKAY;
      end
      else if (rd_fire)
      begin
         rvalid <= 1'b1;
         rdata  <= rd_word;
         rresp  <= rd_ok ? lin_div_pkg::RESP_OKAY : lin_div_pkg::RESP_DECERR;
      end
      else if (rready)
         rvalid <= 1'b0;
   end
   // Software registers: control, mask, and the nominal divider halves.
   always_comb
   begin
      nominal_rate_divider_next = nominal_rate_divider_reg;
      if (wr_a)
         nominal_rate_divider_next[11:4] = wdata[7:0];
      if (wr_b)
      begin
         nominal_rate_divider_next[15:12] = wdata[7:4];
         nominal_rate_divider_next[3:0]   = wdata[3:0];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         nominal_rate_divider_reg <= lin_div_pkg::DIV_RST;
      else
         nominal_rate_divider_reg <= nominal_rate_divider_next;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg <= lin_div_pkg::CTRL_RST;
         mask_reg <= lin_div_pkg::ST_RST;
      end
      else if (wr_fire && wstrb[0])
      begin
         if (awaddr == lin_div_pkg::OFS_CTRL)
            ctrl_reg <= wdata[1:0];
         if (awaddr == lin_div_pkg::OFS_MASK)
            mask_reg <= wdata[lin_div_pkg::ST_W-1:0];
      end
   end

   // Sync field measurement.
   sync_period_meter u_meter
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (break_detected),
      .rx_in   (rx_in),
      .done    (meas_done),
      .period  (meas_period)
   );

   // Eight bit times lie between the first and fifth falling edge.
   assign meas_value = meas_period[18:3];
   assign dev_err    = lin_div_pkg::deviation_exceeds(meas_value, active_rate_divider,
                          lin_div_pkg::HDR_DEV_NUM, lin_div_pkg::HDR_DEV_DEN);
   assign meas_ok    = meas_done & ~dev_err & (hdr_state_reg == lin_div_pkg::HDR_MEASURE);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         measured_rate_divider_reg <= lin_div_pkg::DIV_RST;
      else if (meas_done)
         measured_rate_divider_reg <= meas_value;
   end

   // Register reads show the measured divider until software writes either half.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         show_meas_reg <= 1'b0;
      else if (wr_a || wr_b)
         show_meas_reg <= 1'b0;
      else if (meas_ok)
         show_meas_reg <= 1'b1;
   end

   // Active divider update with nominal priority.
   assign nom_load  = divider_update_mode ? rx_char_valid : wr_a;
   assign meas_load = meas_ok & auto_resync_enable;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         active_rate_divider <= lin_div_pkg::DIV_RST;
      else if (nom_load)
         active_rate_divider <= nominal_rate_divider_next;
      else if (meas_load)
         active_rate_divider <= meas_value;
   end

   baud_rate_gen u_baud
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .divider (active_rate_divider),
      .tick    (baud_tick)
   );

   // Header checking.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hdr_state_reg <= lin_div_pkg::HDR_IDLE;
      else if (break_detected)
         hdr_state_reg <= lin_div_pkg::HDR_MEASURE;
      else
      begin
         unique case (hdr_state_reg)
            lin_div_pkg::HDR_IDLE:
               hdr_state_reg <= lin_div_pkg::HDR_IDLE;
            lin_div_pkg::HDR_MEASURE:
               if (meas_done)
                  hdr_state_reg <= dev_err ? lin_div_pkg::HDR_IDLE
                                           : lin_div_pkg::HDR_WAIT_SYNC;
            lin_div_pkg::HDR_WAIT_SYNC:
               if (rx_char_valid)
                  hdr_state_reg <= lin_div_pkg::HDR_IDLE;
            default:
               hdr_state_reg <= lin_div_pkg::HDR_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rx_data_reg <= lin_div_pkg::RXD_RST;
      else if (rx_char_valid)
         rx_data_reg <= rx_char;
   end

   // Sticky status: hardware set wins over a write-one clear.
   always_comb
   begin
      status_set = '0;
      status_set[lin_div_pkg::ST_RECEIVE_NOT_EMPTY_FLAG_BIT] = rx_char_valid;
      status_set[lin_div_pkg::ST_MEAS_BIT] = meas_ok;
      status_set[lin_div_pkg::ST_HDR_BIT]  = (hdr_state_reg == lin_div_pkg::HDR_WAIT_SYNC)
                                             & ~break_detected & rx_char_valid
                                             & (rx_char == lin_div_pkg::SYNC_BYTE);
      status_set[lin_div_pkg::ST_HERR_BIT] = (meas_done & dev_err
                                              & (hdr_state_reg == lin_div_pkg::HDR_MEASURE))
                                             | ((hdr_state_reg == lin_div_pkg::HDR_WAIT_SYNC)
                                                & ~break_detected & rx_char_valid
                                                & (rx_char != lin_div_pkg::SYNC_BYTE));
      status_set[lin_div_pkg::ST_DRIFT_BIT] = meas_ok & lin_div_pkg::deviation_exceeds(meas_value,
                                              active_rate_divider, lin_div_pkg::CHAR_DEV_NUM,
                                              lin_div_pkg::CHAR_DEV_DEN);
      status_clr = '0;
      if (wr_fire && wstrb[0] && awaddr == lin_div_pkg::OFS_STATUS)
         status_clr = wdata[lin_div_pkg::ST_W-1:0];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status_reg <= lin_div_pkg::ST_RST;
      else
         status_reg <= (status_reg & ~status_clr) | status_set;
   end

   assign irq = |(status_reg & mask_reg);
   // Checks.
   sequence s_sync_wait;
      hdr_state_reg == lin_div_pkg::HDR_WAIT_SYNC && !break_detected;
   endsequence
   sequence s_bad_sync;
      rx_char_valid && rx_char != lin_div_pkg::SYNC_BYTE;
   endsequence
   a_nominal_wins : assert property (@(posedge aclk) disable iff (!aresetn)
      nom_load && meas_load |=> active_rate_divider == $past(nominal_rate_divider_next))
      else $error("Nominal load lost to measured load.");
   a_meas_resync : assert property (@(posedge aclk) disable iff (!aresetn)
      meas_done && !dev_err && hdr_state_reg == lin_div_pkg::HDR_MEASURE
      && auto_resync_enable && !nom_load |=> active_rate_divider == measured_rate_divider_reg)
      else $error("Measured divider not copied to active.");
   a_receive_not_empty_flag_load : assert property (@(posedge aclk) disable iff (!aresetn)
      divider_update_mode && rx_char_valid
      |=> active_rate_divider == $past(nominal_rate_divider_next)
      && status_reg[lin_div_pkg::ST_RECEIVE_NOT_EMPTY_FLAG_BIT])
      else $error("Nominal not loaded at character end.");
   a_write_a_load : assert property (@(posedge aclk) disable iff (!aresetn)
      !divider_update_mode && wr_a |=> active_rate_divider[11:4] == $past(wdata[7:0]))
      else $error("Register A write did not load active divider.");
   a_active_hold : assert property (@(posedge aclk) disable iff (!aresetn)
      !nom_load && !meas_load |=> $stable(active_rate_divider))
      else $error("Active divider changed without a load.");
   a_nominal_b : assert property (@(posedge aclk) disable iff (!aresetn)
      wr_b |=> nominal_rate_divider_reg[15:12] == $past(wdata[7:4])
      && nominal_rate_divider_reg[3:0] == $past(wdata[3:0]))
      else $error("Register B write not captured.");
   a_meas_capture : assert property (@(posedge aclk) disable iff (!aresetn)
      meas_done |=> measured_rate_divider_reg == $past(meas_period[18:3]))
      else $error("Measurement result not stored.");
   a_readback_meas : assert property (@(posedge aclk) disable iff (!aresetn)
      show_meas_reg && rd_fire && araddr == lin_div_pkg::OFS_DIV_A
      |=> rdata[7:0] == $past(measured_rate_divider_reg[11:4]))
      else $error("Register A does not show measured divider.");
   a_bad_sync_err : assert property (@(posedge aclk) disable iff (!aresetn)
      s_sync_wait ##0 s_bad_sync |=> status_reg[lin_div_pkg::ST_HERR_BIT]
      && $stable(status_reg[lin_div_pkg::ST_HDR_BIT]) ##1 hdr_state_reg != lin_div_pkg::HDR_WAIT_SYNC)
      else $error("Bad sync byte not flagged as header error.");
   a_dev_err : assert property (@(posedge aclk) disable iff (!aresetn)
      meas_done && dev_err && hdr_state_reg == lin_div_pkg::HDR_MEASURE && !break_detected
      |=> status_reg[lin_div_pkg::ST_HERR_BIT] && hdr_state_reg == lin_div_pkg::HDR_IDLE)
      else $error("Deviation above limit not flagged.");
endmodule // lin_baud_divider_update
`default_nettype wire

// ### verification/lin_master_model.sv
// Behavioural LIN master that sends a break, a sync field and characters.
`timescale 1ns/100ps
`default_nettype none
module lin_master_model
(
   // Clock
   input  wire logic       aclk,
   // Line and receiver events
   output var  logic       rx_in,
   output var  logic       break_detected,
   output var  logic       rx_char_valid,
   output var  logic [7:0] rx_char
);
   initial
   begin
      rx_in = 1'b1;
      break_detected = 1'b0;
      rx_char_valid = 1'b0;
      rx_char = 8'h00;
   end
   task automatic send_chr(input logic [7:0] c);
      rx_char <= c;
      rx_char_valid <= 1'b1;
      @(posedge aclk);
      rx_char_valid <= 1'b0;
      rx_char <= ~c;
   endtask
   task automatic send_hdr(input int p, input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, 8'h55, 1'b0};
      @(posedge aclk);
      break_detected <= 1'b1;
      @(posedge aclk);
      break_detected <= 1'b0;
      for (int i = 0; i < 10; i++)
      begin
         rx_in <= f[i];
         repeat (p) @(posedge aclk);
      end
      send_chr(c);
   endtask
endmodule // lin_master_model
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the divider update block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        aclk = 1'b0, aresetn = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0;
   logic        ar_v = 1'b0, r_r = 1'b0, aw_r, w_r, b_v, ar_r, r_v, irq, rx, brk, cv;
   logic        tk, rx_q;
   logic [3:0]  ws = 4'hF;
   logic [4:0]  aw_a = 5'h00, ar_a = 5'h00;
   logic [31:0] wd = 32'h0, rdata, rd_q;
   logic [1:0]  bresp, rresp, rr_q, br_q;
   logic [7:0]  ch, c;
   logic [15:0] act_div;
   int          bad_count = 0, cmp_count = 0, seed = 72756, act = 0, st, nf;
   always #5 aclk = ~aclk;
   lin_master_model m (.aclk(aclk), .rx_in(rx), .break_detected(brk), .rx_char_valid(cv),
      .rx_char(ch));
   lin_baud_divider_update dut (.aclk(aclk), .aresetn(aresetn), .awaddr(aw_a),
      .awvalid(aw_v), .awready(aw_r), .wdata(wd), .wstrb(ws), .wvalid(w_v), .wready(w_r),
      .bresp(bresp), .bvalid(b_v), .bready(b_r), .araddr(ar_a), .arvalid(ar_v),
      .arready(ar_r), .rdata(rdata), .rresp(rresp), .rvalid(r_v), .rready(r_r),
      .rx_in(rx), .break_detected(brk), .rx_char_valid(cv), .rx_char(ch),
      .active_rate_divider(act_div), .baud_tick(tk), .irq(irq));
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic hs(input int k);
      int n;
      logic s;
      n = 0;
      do
      begin
         @(negedge aclk);
         n++;
         s = (k == 0) ? (aw_r & w_r) : (k == 1) ? b_v : (k == 2) ? ar_r : r_v;
      end while (s !== 1'b1 && n < 200);
      if (s !== 1'b1)
      begin
         bad_count++;
         test_done;
      end
      rd_q = rdata;
      rr_q = rresp;
      br_q = bresp;
      @(posedge aclk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      aw_a <= a;
      wd <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      hs(0);
      aw_v <= 1'b0;
      w_v <= 1'b0;
      b_r <= 1'b1;
      hs(1);
      b_r <= 1'b0;
      chk("bresp", {30'h0, br_q}, (a > 5'h18) ? 32'h3 : 32'h0);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      ar_a <= a;
      ar_v <= 1'b1;
      hs(2);
      ar_v <= 1'b0;
      r_r <= 1'b1;
      hs(3);
      r_r <= 1'b0;
      chk("rdata", rd_q, e);
      chk("rresp", {30'h0, rr_q}, (a > 5'h18) ? 32'h3 : 32'h0);
   endtask
   task automatic hdr(input int p);
      int ms, d;
      m.send_hdr(p, 8'h55);
      ms = (8 * p - 1) / 8;
      d = (ms > act) ? ms - act : act - ms;
      st = 32'h06;
      if (d * 100 <= act * 14)
      begin
         st = (d * 400 > act * 15) ? 32'h1D : 32'h0D;
         act = ms;
      end
      rd(5'h0C, st);
      rd(5'h14, act);
   endtask
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(5'h14, 32'h0);
      wr(5'h04, 32'h04);
      rd(5'h14, 32'h0);
      wr(5'h00, 32'h06);
      act = 100;
      rd(5'h14, act);
      wr(5'h08, 32'h01);
      hdr(105);
      chk("irq", {31'h0, irq}, 32'h0);
      rd(5'h00, 32'h06);
      rd(5'h04, 32'h08);
      chk("active", {16'h0, act_div}, act);
      wr(5'h10, 32'h01);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(5'h0C, 32'h1F);
      chk("irq", {31'h0, irq}, 32'h0);
      fork
         m.send_hdr(110, 8'h54);
         begin
            nf = 0;
            rx_q = 1'b1;
            for (int n = 0; n < 2000 && nf < 5; n++)
            begin
               @(posedge aclk);
               if (rx_q && !rx)
                  nf++;
               rx_q = rx;
            end
            chk("falls", nf, 5);
            wr(5'h00, 32'h09);
         end
      join
      act = 148;
      rd(5'h14, act);
      rd(5'h0C, 32'h1E);
      rd(5'h00, 32'h09);
      wr(5'h0C, 32'h1F);
      hdr(120);
      wr(5'h0C, 32'h1F);
      wr(5'h08, 32'h03);
      wr(5'h00, 32'h07);
      rd(5'h14, act);
      c = 8'($random(seed));
      m.send_chr(c);
      rd(5'h14, 32'h74);
      rd(5'h18, {24'h0, c});
      rd(5'h1C, 32'h0);
      ws <= 4'h0;
      wr(5'h00, 32'hFF);
      ws <= 4'hF;
      rd(5'h00, 32'h07);
      repeat (200) @(posedge aclk);
      nf = 0;
      repeat (348)
      begin
         @(negedge aclk);
         if (tk === 1'b1)
            nf++;
      end
      chk("ticks", nf, 3);
      test_done;
   end
endmodule // testbench
`default_nettype wire
